// ===== core/pefc_consts.svh
/*
 * Constants of the performance-event fixed counters: register offsets,
 * field positions, event encodings and reset values.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef PEFC_CONSTS_SVH
`define PEFC_CONSTS_SVH

// Widths
`define PEFC_CNT_W           64
`define PEFC_ADDR_W          12
`define PEFC_CODE_W          8

// Register offsets (plain register port, word per offset)
`define PEFC_OFS_FIXED_CTRL  12'h300
`define PEFC_OFS_STATUS      12'h301
`define PEFC_OFS_FIXED0      12'h309
`define PEFC_OFS_FIXED1      12'h30A
`define PEFC_OFS_FIXED2      12'h30B
`define PEFC_OFS_EVSEL0      12'h310
`define PEFC_OFS_EVSEL1      12'h311
`define PEFC_OFS_GP0         12'h312
`define PEFC_OFS_GP1         12'h313

// Fixed counter control fields
`define PEFC_FC_EN0_BIT      0
`define PEFC_FC_EN1_BIT      1
`define PEFC_FC_EN2_BIT      2
`define PEFC_FC_ANY_BIT      6

// Event select fields
`define PEFC_ES_EVT_LSB      0
`define PEFC_ES_MASK_LSB     8
`define PEFC_ES_EN_BIT       22

// Status fields
`define PEFC_ST_SELF_HALT    0
`define PEFC_ST_SIB_HALT     1
`define PEFC_ST_STOPCLK      2
`define PEFC_ST_SIB_PRESENT  3

// Architectural event encodings
`define PEFC_EV_CYCLES       8'h3C
`define PEFC_EV_LLC          8'h2E
`define PEFC_EV_INST         8'hC0
`define PEFC_EV_BRANCH       8'hC4
`define PEFC_EV_BR_MISS      8'hC5
`define PEFC_UM_CORE         8'h00
`define PEFC_UM_REF          8'h01
`define PEFC_UM_LLC_REF      8'h4F
`define PEFC_UM_LLC_MISS     8'h41

// Reset values
`define PEFC_RST_CNT         64'h0000_0000_0000_0000
`define PEFC_RST_CTRL        64'h0000_0000_0000_0000
`define PEFC_RST_RDATA       64'h0000_0000_0000_0000

`endif

// ===== core/pefc_pkg.sv
/*
 * Types shared by the performance-event counter modules.
 * Assumes the constants header is on the include path.
 */
`include "pefc_consts.svh"

package pefc_pkg;

   // Retirement and cache events of the monitored logical processor, one cycle each
   typedef struct packed {
      logic uop_retired;          // A micro-operation retired
      logic uop_last;             // It was the last one of its instruction
      logic branch_retired;       // A branch retired
      logic branch_mispredicted;  // A mispredicted branch retired
      logic llc_reference;        // last_level_cache reference
      logic llc_miss;             // last_level_cache miss
   } pefc_retire_s;

   // Halt status of one logical processor, levels
   typedef struct packed {
      logic halt_instruction;         // Parked by halt_instruction
      logic monitor_wait_instruction; // Parked by monitor_wait_instruction
      logic stop_clock;               // thermal_monitor stop-clock state
   } pefc_halt_s;

   // Decoded class of a general-purpose event selection
   typedef enum logic [6:0] {
      PEFC_EV_NONE     = 7'h01,
      PEFC_EV_CORE_CYC = 7'h02,
      PEFC_EV_REF_CYC  = 7'h04,
      PEFC_EV_INST_RET = 7'h08,
      PEFC_EV_LLC_REF  = 7'h10,
      PEFC_EV_LLC_MISS = 7'h20,
      PEFC_EV_BR_RET   = 7'h40
   } pefc_event_e;

   // Decoded class for branch misses uses its own flag
   typedef struct packed {
      pefc_event_e kind;
      logic        br_miss;
   } pefc_decode_s;

   typedef logic [`PEFC_CNT_W-1:0] pefc_count_t;

endpackage : pefc_pkg

// ===== core/pefc_counter.sv
/*
 * One 64-bit event counter: software load, otherwise add one per event.
 * Assumes an asynchronous active-low reset already released in step with clk_i.
 */
`timescale 1ns/1ps
`include "pefc_consts.svh"

module pefc_counter
   import pefc_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_b_i,
   // Software load
   input  wire logic        load_i,
   input  wire pefc_count_t load_value_i,
   // Event
   input  wire logic        inc_i,
   // Running value
   output      pefc_count_t count_o
);

   // Load beats the increment of the same cycle; wraps silently at the top
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         count_o <= `PEFC_RST_CNT;
      end else if (load_i) begin
         count_o <= load_value_i;
      end else if (inc_i) begin
         count_o <= count_o + `PEFC_CNT_W'(1);
      end
   end

endmodule : pefc_counter

// ===== core/pefc_top.sv
/*
 * Performance-event logic of one logical processor: three fixed-function
 * counters and two general-purpose counters with architectural event select.
 * Assumes clk_i is the actual core clock, all event inputs are synchronous
 * one-cycle pulses or levels in that clock, and ref_tick_i pulses once per
 * time-stamp counter increment.
 */
`timescale 1ns/1ps
`include "pefc_consts.svh"

// What this block does
// - Cycle and instruction architectural encodings counted
// - Event 2E mask 4F counts cache references
// - Event 2E mask 41 counts cache misses
// - Event C4 mask 00 counts retired branches
// - Event C5 mask 00 counts mispredicted branches
// - Fixed counters have hard-wired events only
// - Fixed counter 0 counts last retired uop
// - Instruction count continues during interrupts
// - Fixed counter 1 counts unhalted thread cycles
// - Single-thread core counts its own cycles
// - Bit 6 makes counter 1 any-thread
// - Core cycles follow actual core clock
// - Fixed counter 2 skips halt and stop-clock
// - Halt and monitor-wait both mean halted
// - Reference counter ticks at time-stamp rate
module pefc_top
   import pefc_pkg::*;
(
   // Clock and reset
   input  wire logic                    clk_i,
   input  wire logic                    rst_b_i,
   // Register port
   input  wire logic [`PEFC_ADDR_W-1:0] reg_addr_i,
   input  wire pefc_count_t             reg_wdata_i,
   input  wire logic                    reg_we_i,
   input  wire logic                    reg_re_i,
   output      pefc_count_t             reg_rdata_o,
   // Core status
   input  wire pefc_retire_s            retire_i,
   input  wire pefc_halt_s              self_halt_i,
   input  wire pefc_halt_s              sibling_halt_i,
   input  wire logic                    sibling_present_i,
   input  wire logic                    ref_tick_i
);

   // Reset release chain
   logic                    rst_meta;
   logic                    rst_sync_b;

   // Software state
   pefc_count_t             fixed_ctrl;
   pefc_count_t             evsel0;
   pefc_count_t             evsel1;

   // Counter values
   pefc_count_t             fixed0_count;
   pefc_count_t             fixed1_count;
   pefc_count_t             fixed2_count;
   pefc_count_t             gp0_count;
   pefc_count_t             gp1_count;

   // Qualified events
   logic                    self_halted;
   logic                    sibling_halted;
   logic                    self_unhalted;
   logic                    any_unhalted;
   logic                    ref_cycle;
   logic                    inst_retired;
   logic                    fixed1_event;
   logic                    gp0_event;
   logic                    gp1_event;

   // Register port decode
   logic                    wr_fixed0;
   logic                    wr_fixed1;
   logic                    wr_fixed2;
   logic                    wr_gp0;
   logic                    wr_gp1;
   pefc_count_t             status_word;
   pefc_count_t             next_rdata;

   // Halted when parked by either wait instruction
   function automatic logic is_halted(input pefc_halt_s h);
      is_halted = h.halt_instruction | h.monitor_wait_instruction;
   endfunction : is_halted

   // Map event number and unit mask to an event class; unknown codes count nothing
   function automatic pefc_decode_s decode_select(input pefc_count_t sel);
      logic [`PEFC_CODE_W-1:0] evt;
      logic [`PEFC_CODE_W-1:0] um;
      pefc_decode_s            d;
      evt       = sel[`PEFC_ES_EVT_LSB +: `PEFC_CODE_W];
      um        = sel[`PEFC_ES_MASK_LSB +: `PEFC_CODE_W];
      d.kind    = PEFC_EV_NONE;
      d.br_miss = 1'b0;
      if (evt == `PEFC_EV_CYCLES && um == `PEFC_UM_CORE) begin
         d.kind = PEFC_EV_CORE_CYC;
      end else if (evt == `PEFC_EV_CYCLES && um == `PEFC_UM_REF) begin
         d.kind = PEFC_EV_REF_CYC;
      end else if (evt == `PEFC_EV_INST && um == `PEFC_UM_CORE) begin
         d.kind = PEFC_EV_INST_RET;
      end else if (evt == `PEFC_EV_LLC && um == `PEFC_UM_LLC_REF) begin
         d.kind = PEFC_EV_LLC_REF;
      end else if (evt == `PEFC_EV_LLC && um == `PEFC_UM_LLC_MISS) begin
         d.kind = PEFC_EV_LLC_MISS;
      end else if (evt == `PEFC_EV_BRANCH && um == `PEFC_UM_CORE) begin
         d.kind = PEFC_EV_BR_RET;
      end else if (evt == `PEFC_EV_BR_MISS && um == `PEFC_UM_CORE) begin
         d.br_miss = 1'b1;
      end
      decode_select = d;
   endfunction : decode_select

   // One-cycle event of a general-purpose counter for its selection
   function automatic logic select_event(input pefc_count_t sel,
                                         input logic        core_cyc,
                                         input logic        ref_cyc,
                                         input logic        inst,
                                         input pefc_retire_s r);
      pefc_decode_s d;
      logic         hit;
      d   = decode_select(sel);
      hit = 1'b0;
      unique case (d.kind)
         PEFC_EV_NONE:     hit = d.br_miss & r.branch_mispredicted;
         PEFC_EV_CORE_CYC: hit = core_cyc;
         PEFC_EV_REF_CYC:  hit = ref_cyc;
         PEFC_EV_INST_RET: hit = inst;
         PEFC_EV_LLC_REF:  hit = r.llc_reference;
         PEFC_EV_LLC_MISS: hit = r.llc_miss;
         PEFC_EV_BR_RET:   hit = r.branch_retired;
      endcase
      select_event = hit & sel[`PEFC_ES_EN_BIT];
   endfunction : select_event

   // Reset released through two flops so every counter leaves reset together
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_meta   <= 1'b0;
         rst_sync_b <= 1'b0;
      end else begin
         rst_meta   <= 1'b1;
         rst_sync_b <= rst_meta;
      end
   end

   // Write strobes per counter; writes preset the running value
   assign wr_fixed0 = reg_we_i && reg_addr_i == `PEFC_OFS_FIXED0;
   assign wr_fixed1 = reg_we_i && reg_addr_i == `PEFC_OFS_FIXED1;
   assign wr_fixed2 = reg_we_i && reg_addr_i == `PEFC_OFS_FIXED2;
   assign wr_gp0    = reg_we_i && reg_addr_i == `PEFC_OFS_GP0;
   assign wr_gp1    = reg_we_i && reg_addr_i == `PEFC_OFS_GP1;

   // Fixed counter control: enables and the all-threads qualifier
   always_ff @(posedge clk_i or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         fixed_ctrl <= `PEFC_RST_CTRL;
      end else if (reg_we_i && reg_addr_i == `PEFC_OFS_FIXED_CTRL) begin
         fixed_ctrl <= reg_wdata_i;
      end
   end

   // Event selects only steer the general-purpose counters
   always_ff @(posedge clk_i or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         evsel0 <= `PEFC_RST_CTRL;
         evsel1 <= `PEFC_RST_CTRL;
      end else begin
         if (reg_we_i && reg_addr_i == `PEFC_OFS_EVSEL0) begin
            evsel0 <= reg_wdata_i;
         end
         if (reg_we_i && reg_addr_i == `PEFC_OFS_EVSEL1) begin
            evsel1 <= reg_wdata_i;
         end
      end
   end

   // Halt and unhalted qualifiers
   assign self_halted    = is_halted(self_halt_i);
   assign sibling_halted = is_halted(sibling_halt_i);
   assign self_unhalted  = !self_halted;
   // An absent sibling never counts as unhalted, so one thread means own cycles
   assign any_unhalted   = self_unhalted | (sibling_present_i & !sibling_halted);

   // Reference cycles: time-stamp ticks, not core edges, so frequency does not matter
   assign ref_cycle = ref_tick_i & !self_halted & !self_halt_i.stop_clock;

   // Count an instruction once, on its final micro-operation; interrupts do not gate it
   assign inst_retired = retire_i.uop_retired & retire_i.uop_last;

   // Per-core-clock event, so the count follows frequency changes
   assign fixed1_event = fixed_ctrl[`PEFC_FC_ANY_BIT] ? any_unhalted : self_unhalted;

   // General-purpose events from the programmable selects
   assign gp0_event = select_event(evsel0, self_unhalted, ref_cycle, inst_retired, retire_i);
   assign gp1_event = select_event(evsel1, self_unhalted, ref_cycle, inst_retired, retire_i);

   // Fixed counter 0: hard-wired to retired instructions, no select input
   pefc_counter u_fixed0 (
      .clk_i        (clk_i),
      .rst_b_i      (rst_sync_b),
      .load_i       (wr_fixed0),
      .load_value_i (reg_wdata_i),
      .inc_i        (inst_retired & fixed_ctrl[`PEFC_FC_EN0_BIT]),
      .count_o      (fixed0_count)
   );

   // Fixed counter 1: hard-wired to unhalted core cycles
   pefc_counter u_fixed1 (
      .clk_i        (clk_i),
      .rst_b_i      (rst_sync_b),
      .load_i       (wr_fixed1),
      .load_value_i (reg_wdata_i),
      .inc_i        (fixed1_event & fixed_ctrl[`PEFC_FC_EN1_BIT]),
      .count_o      (fixed1_count)
   );

   // Fixed counter 2: hard-wired to unhalted reference cycles
   pefc_counter u_fixed2 (
      .clk_i        (clk_i),
      .rst_b_i      (rst_sync_b),
      .load_i       (wr_fixed2),
      .load_value_i (reg_wdata_i),
      .inc_i        (ref_cycle & fixed_ctrl[`PEFC_FC_EN2_BIT]),
      .count_o      (fixed2_count)
   );

   // General-purpose counter 0
   pefc_counter u_gp0 (
      .clk_i        (clk_i),
      .rst_b_i      (rst_sync_b),
      .load_i       (wr_gp0),
      .load_value_i (reg_wdata_i),
      .inc_i        (gp0_event),
      .count_o      (gp0_count)
   );

   // General-purpose counter 1
   pefc_counter u_gp1 (
      .clk_i        (clk_i),
      .rst_b_i      (rst_sync_b),
      .load_i       (wr_gp1),
      .load_value_i (reg_wdata_i),
      .inc_i        (gp1_event),
      .count_o      (gp1_count)
   );

   // Live core status for software
   always_comb begin
      status_word                       = `PEFC_RST_RDATA;
      status_word[`PEFC_ST_SELF_HALT]   = self_halted;
      status_word[`PEFC_ST_SIB_HALT]    = sibling_halted;
      status_word[`PEFC_ST_STOPCLK]     = self_halt_i.stop_clock;
      status_word[`PEFC_ST_SIB_PRESENT] = sibling_present_i;
   end

   // Read mux; counters are sampled live, never stopped
   always_comb begin
      next_rdata = `PEFC_RST_RDATA;
      if (reg_re_i) begin
         unique case (reg_addr_i)
            `PEFC_OFS_FIXED_CTRL: next_rdata = fixed_ctrl;
            `PEFC_OFS_STATUS:     next_rdata = status_word;
            `PEFC_OFS_FIXED0:     next_rdata = fixed0_count;
            `PEFC_OFS_FIXED1:     next_rdata = fixed1_count;
            `PEFC_OFS_FIXED2:     next_rdata = fixed2_count;
            `PEFC_OFS_EVSEL0:     next_rdata = evsel0;
            `PEFC_OFS_EVSEL1:     next_rdata = evsel1;
            `PEFC_OFS_GP0:        next_rdata = gp0_count;
            `PEFC_OFS_GP1:        next_rdata = gp1_count;
            default:              next_rdata = `PEFC_RST_RDATA;
         endcase
      end
   end

   // Read data valid only in the cycle after the strobe, zero otherwise
   always_ff @(posedge clk_i or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         reg_rdata_o <= `PEFC_RST_RDATA;
      end else begin
         reg_rdata_o <= next_rdata;
      end
   end

endmodule : pefc_top

// ===== test/pefc_top_chk.sv
/* Checker of the performance-event block, seeing only the top ports.
   Assumes the one core clock and the active-low reset of pefc_top. */
`timescale 1ns/1ps
`include "pefc_consts.svh"
module pefc_top_chk
   import pefc_pkg::*;
(
   // Clock and reset
   input wire logic                    clk_i,
   input wire logic                    rst_b_i,
   // Register port
   input wire logic [`PEFC_ADDR_W-1:0] reg_addr_i,
   input wire pefc_count_t             reg_wdata_i,
   input wire logic                    reg_we_i,
   input wire logic                    reg_re_i,
   input wire pefc_count_t             reg_rdata_o,
   // Core status
   input wire pefc_retire_s            retire_i,
   input wire pefc_halt_s              self_halt_i,
   input wire pefc_halt_s              sibling_halt_i,
   input wire logic                    sibling_present_i,
   input wire logic                    ref_tick_i
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   // Decoded reads and halt levels
   wire rd0 = reg_re_i && reg_addr_i == `PEFC_OFS_FIXED0;
   wire rd1 = reg_re_i && reg_addr_i == `PEFC_OFS_FIXED1;
   wire rd2 = reg_re_i && reg_addr_i == `PEFC_OFS_FIXED2;
   wire rds = reg_re_i && reg_addr_i == `PEFC_OFS_STATUS;
   wire stor = reg_addr_i inside {`PEFC_OFS_FIXED_CTRL, `PEFC_OFS_FIXED0, `PEFC_OFS_FIXED1, `PEFC_OFS_FIXED2};
   wire maps = stor || reg_addr_i inside {[`PEFC_OFS_EVSEL0:`PEFC_OFS_GP1], `PEFC_OFS_STATUS};
   wire s_h = self_halt_i.halt_instruction | self_halt_i.monitor_wait_instruction;
   wire o_h = sibling_halt_i.halt_instruction | sibling_halt_i.monitor_wait_instruction;
   property p_idle; !reg_re_i |=> reg_rdata_o == '0; endproperty
   property p_unmap; reg_re_i && !maps |=> reg_rdata_o == '0; endproperty
   property p_wrrd;
      reg_we_i && stor ##1 reg_re_i && reg_addr_i == $past(reg_addr_i) |=> reg_rdata_o == $past(reg_wdata_i, 2);
   endproperty
   property p_hold0; rd0 && !(retire_i.uop_retired && retire_i.uop_last) ##1 rd0 |=> $stable(reg_rdata_o); endproperty
   property p_hold1; rd1 && s_h && (o_h || !sibling_present_i) ##1 rd1 |=> $stable(reg_rdata_o); endproperty
   property p_hold2; rd2 && !ref_tick_i ##1 rd2 |=> $stable(reg_rdata_o); endproperty
   property p_stop2; rd2 && (self_halt_i.stop_clock || s_h) ##1 rd2 |=> $stable(reg_rdata_o); endproperty
   property p_stat;
      rds |=> reg_rdata_o[3:0] == {$past(sibling_present_i), $past(self_halt_i.stop_clock), $past(o_h), $past(s_h)};
   endproperty
   a_idle: assert property (p_idle) else $error("read data not idle");
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   a_wrrd: assert property (p_wrrd) else $error("written value not read back");
   a_hold0: assert property (p_hold0) else $error("instruction count moved");
   a_hold1: assert property (p_hold1) else $error("cycle count moved while halted");
   a_hold2: assert property (p_hold2) else $error("reference count moved without tick");
   a_stop2: assert property (p_stop2) else $error("reference count moved while stopped");
   a_stat: assert property (p_stat) else $error("status word wrong");
   // Main scenarios reached
   c_wrrd: cover property (p_wrrd);
   c_hold1: cover property (rd1 ##1 rd1);
   c_stop2: cover property (rd2 && s_h ##1 rd2);
endmodule : pefc_top_chk
bind pefc_top pefc_top_chk pefc_top_chk_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
   .retire_i(retire_i), .self_halt_i(self_halt_i), .sibling_halt_i(sibling_halt_i),
   .sibling_present_i(sibling_present_i), .ref_tick_i(ref_tick_i));

// ===== test/pefc_core_model.sv
/* Time-stamp reference tick source standing beside the core.
   Assumes clk_i is the core clock and rst_b_i the bench reset. */
`timescale 1ns/1ps
module pefc_core_model #(
   parameter int REF_DIV = 3  // Core cycles per tick
) (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_b_i,
   // Reference tick
   output logic      ref_tick_o
);
   int div;
   // Free-running, blind to halt and stop-clock like a real time base
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         div        <= 0;
         ref_tick_o <= 1'b0;
      end else begin
         div        <= (div == REF_DIV - 1) ? 0 : div + 1;
         ref_tick_o <= (div == REF_DIV - 1);
      end
   end
endmodule : pefc_core_model

// ===== test/tb_top.sv
/* Self-checking bench of the performance-event block.
   Assumes the checker is bound and the tick model feeds ref_tick_i. */
`timescale 1ns/1ps
`include "pefc_consts.svh"
module tb_top
   import pefc_pkg::*;
;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [11:0] reg_addr_i = '0;
   pefc_count_t reg_wdata_i = '0;
   logic reg_we_i = 1'b0;
   logic reg_re_i = 1'b0;
   pefc_count_t reg_rdata_o;
   pefc_retire_s retire_i = '0;
   pefc_halt_s self_halt_i = '0;
   pefc_halt_s sibling_halt_i = '0;
   logic sibling_present_i = 1'b0;
   logic ref_tick_i;
   int n_mismatch = 0;
   int n_tests = 0;
   int n_tick = 0;
   int n_cyc = 0;
   always #10 clk_i = ~clk_i;
   pefc_top pefc_top_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .retire_i(retire_i),
      .self_halt_i(self_halt_i), .sibling_halt_i(sibling_halt_i), .sibling_present_i(sibling_present_i),
      .ref_tick_i(ref_tick_i));
   pefc_core_model #(.REF_DIV(3)) pefc_core_model_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .ref_tick_o(ref_tick_i));
   // Ticks counted where settled, off the sampling edge
   always @(negedge clk_i) if (ref_tick_i === 1'b1) n_tick++;
   task automatic check(input string what, input pefc_count_t seen, input pefc_count_t exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [11:0] a, input pefc_count_t d);
      reg_we_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge clk_i);
      // Strobe left up; the next read or stimulus phase lowers it, so back-to-back writes keep it up without a gap
   endtask : wr
   // Read data stand one cycle only, so sample in that cycle
   task automatic rd2(input logic [11:0] a, input int two, output pefc_count_t v0, output pefc_count_t v1);
      reg_we_i <= 1'b0;
      reg_re_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge clk_i);
      if (two == 0) reg_re_i <= 1'b0;
      @(negedge clk_i) v0 = reg_rdata_o;
      @(posedge clk_i);
      reg_re_i <= 1'b0;
      @(negedge clk_i) v1 = reg_rdata_o;
      @(posedge clk_i);
   endtask : rd2
   // Preset a counter, hold stimulus for n edges, read it back
   task automatic measure(input logic [11:0] a, input pefc_count_t p, input int n, input pefc_retire_s r,
                          output pefc_count_t v, output int t);
      pefc_count_t z;
      int t0;
      wr(a, p);
      if (n > 0) begin
         reg_we_i <= 1'b0;
         retire_i <= r;
      end
      t0 = n_tick;
      repeat (n) @(posedge clk_i);
      if (n > 0) retire_i <= '0;
      t = n_tick - t0;
      rd2(a, 0, v, z);
      check("idle read data", z, 64'h0);
   endtask : measure
   task automatic s_reset();
      logic [11:0] ad[6] = '{12'h300, 12'h309, 12'h30A, 12'h30B, 12'h312, 12'h305};
      pefc_count_t v;
      pefc_count_t z;
      foreach (ad[i]) begin
         rd2(ad[i], 0, v, z);
         check("reset value", v, 64'h0);
      end
   endtask : s_reset
   task automatic s_fixed0();
      pefc_count_t v;
      int t;
      wr(`PEFC_OFS_FIXED_CTRL, 64'h7);
      measure(`PEFC_OFS_FIXED0, 64'h0, 5, 6'h20, v, t);
      check("fixed0 partial uops", v, 64'h0);
      measure(`PEFC_OFS_FIXED0, 64'hFFFF_FFFF_FFFF_FFFE, 3, 6'h30, v, t);
      check("fixed0 wrap", v, 64'h1);
      measure(`PEFC_OFS_FIXED2, 64'h1234, 0, '0, v, t);
      check("preset read", v, 64'h1234);
   endtask : s_fixed0
   task automatic s_fixed1();
      pefc_halt_s hs[4] = '{3'h0, 3'h1, 3'h4, 3'h2};
      logic [11:0] ad[3] = '{12'h309, 12'h30A, 12'h30B};
      pefc_count_t v;
      pefc_count_t w;
      int t;
      foreach (hs[i]) begin
         self_halt_i <= hs[i];
         measure(`PEFC_OFS_FIXED1, 64'h0, 6, '0, v, t);
         check("fixed1 cycles", v, (i < 2) ? 64'h6 : 64'h0);
         measure(`PEFC_OFS_FIXED2, 64'h0, 12, '0, v, t);
         check("fixed2 cycles", v, (i == 0) ? pefc_count_t'(t) : 64'h0);
      end
      sibling_present_i <= 1'b1;
      measure(`PEFC_OFS_FIXED1, 64'h0, 6, '0, v, t);
      check("fixed1 own thread", v, 64'h0);
      wr(`PEFC_OFS_FIXED_CTRL, 64'h47);
      rd2(`PEFC_OFS_FIXED_CTRL, 0, v, w);
      check("control readback", v, 64'h47);
      measure(`PEFC_OFS_FIXED1, 64'h0, 6, '0, v, t);
      check("fixed1 any thread", v, 64'h6);
      sibling_halt_i <= 3'h2;
      measure(`PEFC_OFS_FIXED1, 64'h0, 6, '0, v, t);
      check("fixed1 both halted", v, 64'h0);
      sibling_halt_i <= 3'h0;
      sibling_present_i <= 1'b0;
      measure(`PEFC_OFS_FIXED1, 64'h0, 6, '0, v, t);
      check("fixed1 lone thread", v, 64'h0);
      wr(`PEFC_OFS_STATUS, 64'hF);
      rd2(`PEFC_OFS_STATUS, 0, v, w);
      check("status read only", v, 64'h1);
      foreach (ad[i]) begin
         rd2(ad[i], 1, v, w);
         check("halted counter still", w, v);
      end
      self_halt_i <= 3'h0;
   endtask : s_fixed1
   task automatic s_gp();
      logic [15:0] cd[9] = '{16'h003C, 16'h013C, 16'h00C0, 16'h4F2E, 16'h412E, 16'h412E, 16'h00C4, 16'h00C5,
                             16'h023C};
      pefc_retire_s rr[9] = '{6'h00, 6'h00, 6'h30, 6'h02, 6'h01, 6'h02, 6'h08, 6'h04, 6'h3F};
      int ex[9] = '{4, -1, 4, 4, 4, 0, 4, 4, 0};
      pefc_count_t v;
      int t;
      foreach (cd[i]) begin
         wr(`PEFC_OFS_EVSEL0, 64'h40_0000 | 64'(cd[i]));
         measure(`PEFC_OFS_GP0, 64'h0, 4, rr[i], v, t);
         check("general event", v, pefc_count_t'((ex[i] < 0) ? t : ex[i]));
      end
   endtask : s_gp
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : print_verdict
   // Hang guard, far above the few hundred cycles needed
   always @(posedge clk_i) begin
      n_cyc++;
      if (n_cyc == 20000) begin
         n_mismatch++;
         print_verdict();
      end
   end
   initial begin
      repeat (12) @(posedge clk_i);
      rst_b_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      s_reset();
      s_fixed0();
      s_fixed1();
      s_gp();
      print_verdict();
   end
endmodule : tb_top
